// ==== rtl/psd_pkg.sv ====
// Constants and field layout of the power switch diagnosis block
package psd_pkg;
	// Channel count and link framing
	localparam int NCH = 4;
	localparam int FRAME_BITS = 8;
	localparam logic [3:0] CNT_FRAME = 4'h8;
	localparam logic [3:0] CNT_MAX = 4'hf;
	localparam logic [3:0] CNT_LAST = 4'h7;
	localparam logic [3:0] CNT_CLR_OPEN = 4'h1;
	localparam logic [3:0] CNT_CLR_SHUT = 4'h2;

	// Command byte layout
	localparam int CMD_WRITE_POS = 7;
	localparam int CMD_ADDR_MSB = 6;
	localparam int CMD_ADDR_LSB = 4;
	localparam logic [2:0] CMD_HW_CONFIG = 3'h6;
	localparam logic [2:0] CMD_DIAG_CONTROL = 3'h5;
	localparam logic [2:0] CMD_SOURCE_CONFIG = 3'h4;

	// Hardware configuration command fields
	localparam int HW_CLEAR_LATCH_POS = 0;
	localparam int HW_CFG_RESET_POS = 1;
	localparam int HW_LED_LSB = 2;
	localparam int HW_LED_MSB = 3;

	// Diagnosis control and source configuration command fields
	localparam int DC_SRC_EN_POS = 3;
	localparam int DC_SEL_MSB = 2;
	localparam int DC_SEL_LSB = 0;
	localparam int SC_LEVEL_POS = 0;

	// Sense selection codes and reset values
	localparam logic [2:0] SEL_CH_LAST = 3'h3;
	localparam logic [2:0] SEL_DISABLE = 3'h7;
	localparam logic [2:0] SEL_RESET = 3'h7;
	localparam logic [1:0] LED_RESET = 2'h0;
	localparam logic SRC_EN_RESET = 1'b0;
	localparam logic SRC_LEVEL_RESET = 1'b0;

	// Standard diagnosis word layout
	localparam int DG_ERR_LSB = 0;
	localparam int DG_SBM_POS = 4;
	localparam int DG_LIMP_POS = 5;
	localparam int DG_ZERO_POS = 6;
	localparam int DG_TER_POS = 7;
	localparam logic [7:0] DG_RESET = 8'h00;

	// Over-current latch applies at once on these channels
	localparam logic [3:0] OC_LATCH_CH = 4'h3;

	// Restart retry limits
	localparam int RETRY_W = 6;
	localparam logic [5:0] RETRY_LOW_VDS = 6'h20;
	localparam logic [5:0] RETRY_MED_VDS = 6'h08;

	// Synchroniser vector positions
	localparam int SV_FRAME = 0;
	localparam int SV_RXT = 1;
	localparam int SV_WIN = 2;
	localparam int SV_LEN = 3;
	localparam int SV_LIMP = 4;
	localparam int SV_OT = 5;
	localparam int SV_OC = 9;
	localparam int SV_OL = 13;
	localparam int SV_DTS = 17;
	localparam int SV_MED = 21;
	localparam int SV_VDS = 25;
	localparam int SV_W = 29;
endpackage : psd_pkg

// ==== rtl/psd_link_if.sv ====
// Signals passed between the link-clock logic and the core
interface psd_link_if;
	logic [7:0] rx_byte;
	logic rx_tgl;
	logic clr_win;
	logic len_ok;
	logic [7:0] diag_word;

	modport link (
		output rx_byte,
		output rx_tgl,
		output clr_win,
		output len_ok,
		input diag_word
	);

	modport core (
		input rx_byte,
		input rx_tgl,
		input clr_win,
		input len_ok,
		output diag_word
	);
endinterface : psd_link_if

// ==== rtl/psd_spi_link.sv ====
// Serial link logic clocked by the host's serial clock
module psd_spi_link
	import psd_pkg::*;
(
	// Reset
	input wire logic rst_n,
	// Serial pins
	input wire logic sclk,
	input wire logic csn_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Core side
	psd_link_if.link lnk
);

	logic frame_rst_n;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic win_q;
	logic win_d;
	logic [7:0] rx_byte_q;
	logic rx_tgl_q;
	logic len_ok_q;
	logic byte_done;
	logic [2:0] tx_idx;

	// Frame state ends with the select line, since the clock stops
	assign frame_rst_n = rst_n & ~csn_n;
	assign bit_cnt_d = (bit_cnt_q == CNT_MAX) ? bit_cnt_q : bit_cnt_q + 4'h1;
	assign shift_d = {shift_q[6:0], mosi};
	assign byte_done = (bit_cnt_q == CNT_LAST);

	// Clear window opens at the second rising edge, shuts at the third
	assign win_d = (bit_cnt_q == CNT_CLR_OPEN) ? 1'b1 :
		(bit_cnt_q == CNT_CLR_SHUT) ? 1'b0 : win_q;

	// Bit counter, shifter and clear window
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			win_q <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			win_q <= win_d;
		end
	end

	// Received byte and its toggle outlive the frame
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_byte_q <= 8'h00;
			rx_tgl_q <= 1'b0;
			len_ok_q <= 1'b1;
		end else begin
			len_ok_q <= (bit_cnt_d == CNT_FRAME);
			if (byte_done) begin
				rx_byte_q <= shift_d;
				rx_tgl_q <= ~rx_tgl_q;
			end
		end
	end

	// Diagnosis word leaves MSB first; frozen by the core in a frame
	assign tx_idx = ~bit_cnt_q[2:0];
	assign miso = (bit_cnt_q < CNT_FRAME) ? lnk.diag_word[tx_idx] : 1'b0;
	assign miso_oe = ~csn_n;

	assign lnk.rx_byte = rx_byte_q;
	assign lnk.rx_tgl = rx_tgl_q;
	assign lnk.clr_win = win_q;
	assign lnk.len_ok = len_ok_q;
endmodule : psd_spi_link

// ==== rtl/psd_diag.sv ====
// Diagnosis core of a four-channel power switch with serial link
// Function
// - Channel error flag is shutdown flags (thermal, over-current, restart) OR over-load monitoring.
// - Over-load events held until read, cleared between edges two and three.
// - Over-temperature, and over-current on channels 0 and 1, latch off.
// - After clear-latch, flag clears next frame and re-arms after edge three.
// - Persisting over-load sets the flag again right after any clear.
// - Selection field routes one channel's sense, or disables sense output.
// - Sense only while selected channel is on and free of faults.
// - Channels 2 and 3 take LED or bulb sense ratio from config bits.
// - Over-load and non-final restart indications clear on each read.
// - Over-temperature, final restart latch, over-current on channels 0 and 1 stay until clear-latch.
// - Bypass monitor on selected channel, seen as status bit and in word.
// - Off-state source enable on selected channel, level bit picks current.
// - Off state: error 0; bypass bit follows selected drain-source level.
// - On state: error 1 for ground short and shutdowns, else 0.
// - Diagnosis word carries four error flags in its low bits.
// - Clear-latch bit 1 clears thermal and over-current latches; 0 leaves them.
// - Restart retries 32 times at low, 8 at medium voltage, then latches.
module psd_diag
	import psd_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Serial link from the host
	input wire logic SCLK,
	input wire logic CSN_N,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	// Channel state from the gate control
	input wire logic [3:0] CHANNEL_ON_REQUEST,
	// Analog monitors, asynchronous
	input wire logic [3:0] OVERTEMP,
	input wire logic [3:0] OVERCURRENT,
	input wire logic [3:0] OVERLOAD,
	input wire logic [3:0] DYN_TEMP_SHUTDOWN,
	input wire logic [3:0] VDS_MEDIUM,
	input wire logic [3:0] VDS_ABOVE_BYPASS,
	input wire logic LIMP_HOME,
	// Protection and diagnosis outputs
	output logic [3:0] LATCH_OFF,
	output logic [3:0] CHANNEL_ERROR_FLAG,
	output logic BYPASS_MONITOR_RESULT,
	// Sense multiplexer outputs
	output logic SENSE_OUTPUT_PIN_ENABLE,
	output logic [2:0] SENSE_CHANNEL_SELECT,
	output logic [1:0] LED_LOAD_SELECT,
	// Off-state current source outputs
	output logic [3:0] OFFSTATE_SOURCE_ENABLE,
	output logic OFFSTATE_SOURCE_LEVEL
);

	psd_link_if lnk ();

	// Link-clock side of the serial interface
	psd_spi_link u_link (
		.rst_n(RST_N),
		.sclk(SCLK),
		.csn_n(CSN_N),
		.mosi(MOSI),
		.miso(MISO),
		.miso_oe(MISO_OE),
		.lnk(lnk.link)
	);

	// Synchroniser state
	logic [SV_W-1:0] sv_raw;
	logic [SV_W-1:0] s1_q;
	logic [SV_W-1:0] s2_q;
	logic [SV_W-1:0] s3_q;
	logic [SV_W-1:0] stab_q;
	logic [SV_W-1:0] stab_d;
	logic [SV_W-1:0] prev_q;

	// Synchronised views
	logic frame_act;
	logic rx_evt;
	logic clr_win;
	logic len_ok;
	logic limp;
	logic [3:0] ot_in;
	logic [3:0] oc_in;
	logic [3:0] ol_in;
	logic [3:0] dts_in;
	logic [3:0] med_in;
	logic [3:0] vds_in;

	// Command decode
	logic [7:0] cmd;
	logic cmd_wr;
	logic [2:0] cmd_addr;
	logic hw_wr;
	logic dc_wr;
	logic sc_wr;
	logic clear_latch;
	logic cfg_reset;

	// Configuration registers
	logic [2:0] sel_q;
	logic [2:0] sel_d;
	logic src_en_q;
	logic src_en_d;
	logic src_lvl_q;
	logic src_lvl_d;
	logic [1:0] led_q;
	logic [1:0] led_d;

	// Protection latches and error flags
	logic [3:0] ot_latch_q;
	logic [3:0] ot_latch_d;
	logic [3:0] oc_latch_q;
	logic [3:0] oc_latch_d;
	logic [3:0] dts_latch_q;
	logic [3:0] dts_latch_d;
	logic [3:0] restart_q;
	logic [3:0] restart_ev;
	logic [3:0] restart_d;
	logic [3:0] err_q;
	logic [3:0] err_d;
	logic [3:0] err_cause;
	logic [3:0] fault;

	// Selected-channel logic
	logic sel_valid;
	logic [1:0] sel_ch;
	logic [3:0] sel_hot;
	logic sbm;
	logic sense_en_q;
	logic sbm_q;
	logic [3:0] src_out_q;
	logic [7:0] snap_q;
	logic [7:0] snap_d;
	logic [7:0] word_now;
	logic sense_en_d;
	logic [3:0] src_out_d;

	// Asynchronous inputs gathered into one vector; the link-side bits
	// cross here too, while the byte itself is held steady by its toggle
	assign sv_raw = {VDS_ABOVE_BYPASS, VDS_MEDIUM, DYN_TEMP_SHUTDOWN,
		OVERLOAD, OVERCURRENT, OVERTEMP, LIMP_HOME, lnk.len_ok,
		lnk.clr_win, lnk.rx_tgl, ~CSN_N};

	// A bit changes only once the second and third stages agree
	assign stab_d = (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));

	// Three-stage synchroniser and filtered value
	// Only the second stage reads the first, so its settling time stays whole
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stab_q <= '0;
			prev_q <= '0;
		end else begin
			s1_q <= sv_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stab_q <= stab_d;
			prev_q <= stab_q;
		end
	end

	// Field views of the filtered vector
	// Frame activity freezes the snapshot; a toggle edge marks a new byte
	assign frame_act = stab_q[SV_FRAME];
	assign rx_evt = stab_q[SV_RXT] ^ prev_q[SV_RXT];
	assign clr_win = stab_q[SV_WIN];
	assign len_ok = stab_q[SV_LEN];
	assign limp = stab_q[SV_LIMP];
	assign ot_in = stab_q[SV_OT +: NCH];
	assign oc_in = stab_q[SV_OC +: NCH];
	assign ol_in = stab_q[SV_OL +: NCH];
	assign dts_in = stab_q[SV_DTS +: NCH];
	assign med_in = stab_q[SV_MED +: NCH];
	assign vds_in = stab_q[SV_VDS +: NCH];

	// Byte is stable for a whole frame after its toggle
	// Only a write to a known address acts; reads change no configuration or latch
	assign cmd = lnk.rx_byte;
	assign cmd_wr = cmd[CMD_WRITE_POS];
	assign cmd_addr = cmd[CMD_ADDR_MSB:CMD_ADDR_LSB];
	assign hw_wr = rx_evt & cmd_wr & (cmd_addr == CMD_HW_CONFIG);
	assign dc_wr = rx_evt & cmd_wr & (cmd_addr == CMD_DIAG_CONTROL);
	assign sc_wr = rx_evt & cmd_wr & (cmd_addr == CMD_SOURCE_CONFIG);
	assign clear_latch = hw_wr & cmd[HW_CLEAR_LATCH_POS];
	assign cfg_reset = hw_wr & cmd[HW_CFG_RESET_POS];

	// Configuration next values; reset bit returns defaults
	// A field write and a configuration reset in one byte: the reset wins
	assign sel_d = cfg_reset ? SEL_RESET :
		dc_wr ? cmd[DC_SEL_MSB:DC_SEL_LSB] : sel_q;
	assign src_en_d = cfg_reset ? SRC_EN_RESET :
		dc_wr ? cmd[DC_SRC_EN_POS] : src_en_q;
	assign src_lvl_d = cfg_reset ? SRC_LEVEL_RESET :
		sc_wr ? cmd[SC_LEVEL_POS] : src_lvl_q;
	assign led_d = cfg_reset ? LED_RESET :
		hw_wr ? cmd[HW_LED_MSB:HW_LED_LSB] : led_q;

	// Configuration registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_q <= SEL_RESET;
			src_en_q <= SRC_EN_RESET;
			src_lvl_q <= SRC_LEVEL_RESET;
			led_q <= LED_RESET;
		end else begin
			sel_q <= sel_d;
			src_en_q <= src_en_d;
			src_lvl_q <= src_lvl_d;
			led_q <= led_d;
		end
	end

	// Latches: a new event wins over a clear in the same cycle
	// so a fault that strikes during the clear is never lost
	assign ot_latch_d = ot_in | (ot_latch_q & ~{NCH{clear_latch}});
	assign oc_latch_d = (oc_in & OC_LATCH_CH) |
		(oc_latch_q & ~{NCH{clear_latch}});

	// Restart events: shutdowns that retry instead of latching at once
	assign restart_d = dts_in | (oc_in & ~OC_LATCH_CH);
	assign restart_ev = restart_d & ~restart_q;

	// Per-channel restart retry counter
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_retry
			logic [RETRY_W-1:0] cnt_q;
			logic [RETRY_W-1:0] cnt_d;
			logic [RETRY_W-1:0] cnt_inc;
			logic [RETRY_W-1:0] limit;
			logic hit;

			// Limit follows the drain-source voltage class
			assign limit = med_in[g] ? RETRY_MED_VDS : RETRY_LOW_VDS;
			// At or above, so a voltage class change mid-count cannot skip the limit
			assign cnt_inc = (cnt_q >= limit) ? cnt_q : cnt_q + 6'h01;
			assign hit = restart_ev[g] & (cnt_inc >= limit);
			assign cnt_d = restart_ev[g] ? cnt_inc :
				clear_latch ? 6'h00 : cnt_q;
			assign dts_latch_d[g] = hit |
				(dts_latch_q[g] & ~clear_latch);

			// Counter state
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					cnt_q <= 6'h00;
				end else begin
					cnt_q <= cnt_d;
				end
			end
		end
	endgenerate

	// Errors count only while a channel is on; any shutdown of an on
	// channel, latched or still retrying, shows in its flag
	assign err_cause = CHANNEL_ON_REQUEST & (ot_latch_q | oc_latch_q |
		dts_latch_q | ol_in | dts_in | oc_in);

	// Window clears the flags; outside it a live cause sets them again
	// Inside the window the clear wins over a live cause, as the read demands
	assign err_d = clr_win ? 4'h0 : (err_q | err_cause);

	// Latches, restart edge memory and error flags
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ot_latch_q <= 4'h0;
			oc_latch_q <= 4'h0;
			dts_latch_q <= 4'h0;
			restart_q <= 4'h0;
			err_q <= 4'h0;
		end else begin
			ot_latch_q <= ot_latch_d;
			oc_latch_q <= oc_latch_d;
			dts_latch_q <= dts_latch_d;
			restart_q <= restart_d;
			err_q <= err_d;
		end
	end

	// Channel faults that silence the sense path
	// Live monitors count too, so sense stops no later than a latch forms
	assign fault = ot_latch_q | oc_latch_q | dts_latch_q |
		ot_in | oc_in | dts_in;

	// Selected channel decode; disable code selects nothing
	// Unused codes behave like the disable code
	assign sel_valid = (sel_q <= SEL_CH_LAST);
	assign sel_ch = sel_q[1:0];
	assign sel_hot = sel_valid ? (4'h1 << sel_ch) : 4'h0;
	assign sbm = |(sel_hot & vds_in);

	// Diagnosis word assembled field by field from the live status
	always_comb begin
		word_now = DG_RESET;
		word_now[DG_ERR_LSB +: NCH] = err_q;
		word_now[DG_SBM_POS] = sbm;
		word_now[DG_LIMP_POS] = limp;
		word_now[DG_ZERO_POS] = 1'b0;
		word_now[DG_TER_POS] = ~len_ok;
	end

	// Snapshot frozen while a frame is active, so the in-frame clear
	// cannot reach the bits already on their way out
	assign snap_d = frame_act ? snap_q : word_now;

	// Next values of the selected-channel registers
	assign sense_en_d = |(sel_hot & CHANNEL_ON_REQUEST & ~fault);
	assign src_out_d = sel_hot & ~CHANNEL_ON_REQUEST & {NCH{src_en_q}};

	// Sense, bypass, source and diagnosis word registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sense_en_q <= 1'b0;
			sbm_q <= 1'b0;
			src_out_q <= 4'h0;
			snap_q <= DG_RESET;
		end else begin
			sense_en_q <= sense_en_d;
			sbm_q <= sbm;
			src_out_q <= src_out_d;
			snap_q <= snap_d;
		end
	end

	// Diagnosis word toward the link side
	// Read across the clock boundary only while frozen by the frame
	assign lnk.diag_word = snap_q;

	// Output ports
	assign LATCH_OFF = ot_latch_q | oc_latch_q | dts_latch_q;
	assign CHANNEL_ERROR_FLAG = err_q;
	assign BYPASS_MONITOR_RESULT = sbm_q;
	assign SENSE_OUTPUT_PIN_ENABLE = sense_en_q;
	assign SENSE_CHANNEL_SELECT = sel_q;
	assign LED_LOAD_SELECT = led_q;
	assign OFFSTATE_SOURCE_ENABLE = src_out_q;
	assign OFFSTATE_SOURCE_LEVEL = src_lvl_q;
endmodule : psd_diag

// ==== verification/psd_chk.sv ====
// Port-level assertions for the power switch diagnosis block
module psd_chk
	import psd_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Inputs watched
	input wire logic CSN_N,
	input wire logic [3:0] CHANNEL_ON_REQUEST,
	input wire logic [3:0] OVERTEMP,
	input wire logic [3:0] OVERCURRENT,
	input wire logic [3:0] OVERLOAD,
	// Outputs watched
	input wire logic [3:0] LATCH_OFF,
	input wire logic [3:0] CHANNEL_ERROR_FLAG,
	input wire logic BYPASS_MONITOR_RESULT,
	input wire logic SENSE_OUTPUT_PIN_ENABLE,
	input wire logic [2:0] SENSE_CHANNEL_SELECT,
	input wire logic [1:0] LED_LOAD_SELECT,
	input wire logic [3:0] OFFSTATE_SOURCE_ENABLE
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] idle_q;
	logic [7:0] idle_d;
	logic recent;

	// Cycles since the frame select was low, saturating
	assign idle_d = !CSN_N ? 8'h00 : ((idle_q == 8'hff) ? idle_q : idle_q + 8'h01);
	assign recent = idle_q < 8'h10;

	// Idle counter register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			idle_q <= 8'hff;
		end else begin
			idle_q <= idle_d;
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	AST_SENSE_SEL: assert property (SENSE_OUTPUT_PIN_ENABLE |->
		$past(SENSE_CHANNEL_SELECT) <= SEL_CH_LAST)
		else $error("sense enabled on a disable code");
	AST_SENSE_OK: assert property (SENSE_OUTPUT_PIN_ENABLE && $stable(SENSE_CHANNEL_SELECT) |->
		(($past(CHANNEL_ON_REQUEST & ~LATCH_OFF) >> SENSE_CHANNEL_SELECT[1:0]) & 4'h1) == 4'h1)
		else $error("sense enabled on an off or latched channel");
	AST_SRC_ONE: assert property ($onehot0(OFFSTATE_SOURCE_ENABLE))
		else $error("source enabled on more than one channel");
	AST_SRC_OFF: assert property ((OFFSTATE_SOURCE_ENABLE & $past(CHANNEL_ON_REQUEST)) == 4'h0)
		else $error("source enabled on a channel that is on");
	AST_NO_CH: assert property ((|OFFSTATE_SOURCE_ENABLE || BYPASS_MONITOR_RESULT) |->
		SENSE_CHANNEL_SELECT <= SEL_CH_LAST || $past(SENSE_CHANNEL_SELECT) <= SEL_CH_LAST)
		else $error("bypass or source active under disable code");
	AST_ERR_OFF: assert property ((CHANNEL_ERROR_FLAG & ~$past(CHANNEL_ERROR_FLAG) &
		~$past(CHANNEL_ON_REQUEST)) == 4'h0)
		else $error("error flag raised on an off channel");
	AST_OT_LATCH: assert property ((OVERTEMP[0] && CHANNEL_ON_REQUEST[0])[*8] |-> LATCH_OFF[0])
		else $error("over-temperature did not latch off");
	AST_OC_LATCH: assert property ((OVERCURRENT[1] && CHANNEL_ON_REQUEST[1])[*8] |-> LATCH_OFF[1])
		else $error("over-current did not latch off");
	AST_ERR_SET: assert property ((OVERLOAD[2] && CHANNEL_ON_REQUEST[2] && CSN_N)[*8] |->
		CHANNEL_ERROR_FLAG[2])
		else $error("over-load not shown in error flag");
	AST_LATCH_HOLD: assert property (|($past(LATCH_OFF) & ~LATCH_OFF) |-> recent)
		else $error("latch cleared without a frame");
	AST_ERR_HOLD: assert property (|($past(CHANNEL_ERROR_FLAG & CHANNEL_ON_REQUEST) &
		~CHANNEL_ERROR_FLAG & CHANNEL_ON_REQUEST) |-> recent)
		else $error("error flag cleared without a frame");
	AST_CFG_HOLD: assert property (!$stable({LED_LOAD_SELECT, SENSE_CHANNEL_SELECT}) |-> recent)
		else $error("configuration changed without a frame");
endmodule : psd_chk

bind psd_diag psd_chk u_psd_chk (.MCLK, .RST_N, .CSN_N, .CHANNEL_ON_REQUEST, .OVERTEMP,
	.OVERCURRENT, .OVERLOAD, .LATCH_OFF, .CHANNEL_ERROR_FLAG, .BYPASS_MONITOR_RESULT,
	.SENSE_OUTPUT_PIN_ENABLE, .SENSE_CHANNEL_SELECT, .LED_LOAD_SELECT, .OFFSTATE_SOURCE_ENABLE);

// ==== verification/psd_host.sv ====
// Serial host model that sends command bytes and reads the diagnosis word
module psd_host (
	// Serial pins
	output logic sclk,
	output logic csn_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels, clock stands still between frames
	initial begin
		sclk = 1'b0;
		csn_n = 1'b1;
		mosi = 1'b0;
	end

	// One frame of nr rises, data out MSB first, diagnosis sampled at each rise
	task automatic xfer(input logic [7:0] tx, input int nr, output logic [7:0] rx);
		rx = 8'h00;
		#13 csn_n = 1'b0;
		#200;
		for (int k = 0; k < nr; k++) begin
			mosi = tx[7 - k];
			#32 rx = {rx[6:0], miso};
			sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		#32 csn_n = 1'b1;
		// Released data line shows the inverse of its last bit
		mosi = ~mosi;
		#200;
	endtask : xfer
endmodule : psd_host

// ==== verification/psd_diag_tb.sv ====
// Self-checking bench for the power switch diagnosis block
module psd_diag_tb
	import psd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_n, sclk, csn_n, mosi, miso, miso_oe, limp, byp, sen, lvl;
	logic [3:0] on_req, ot, oc, ol, dts, vmed, vbyp, latch, err, src;
	logic [2:0] sel;
	logic [1:0] led;
	logic [7:0] rx;
	wire logic miso_w;
	int miscompares;
	int checked;

	// Data line pulled high while the device releases it
	assign miso_w = miso_oe ? miso : 1'b1;

	psd_diag u_psd_diag (.MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CSN_N(csn_n), .MOSI(mosi),
		.MISO(miso), .MISO_OE(miso_oe), .CHANNEL_ON_REQUEST(on_req), .OVERTEMP(ot),
		.OVERCURRENT(oc), .OVERLOAD(ol), .DYN_TEMP_SHUTDOWN(dts), .VDS_MEDIUM(vmed),
		.VDS_ABOVE_BYPASS(vbyp), .LIMP_HOME(limp), .LATCH_OFF(latch), .CHANNEL_ERROR_FLAG(err),
		.BYPASS_MONITOR_RESULT(byp), .SENSE_OUTPUT_PIN_ENABLE(sen), .SENSE_CHANNEL_SELECT(sel),
		.LED_LOAD_SELECT(led), .OFFSTATE_SOURCE_ENABLE(src), .OFFSTATE_SOURCE_LEVEL(lvl));
	psd_host u_psd_host (.sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso_w));

	// Core clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Write one byte, then wait out the core latency
	task automatic cmd(input logic [7:0] b);
		u_psd_host.xfer(b, 8, rx);
		tick(8);
	endtask : cmd

	task automatic rd(input int nr);
		u_psd_host.xfer(8'h00, nr, rx);
		tick(8);
	endtask : rd

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Channel codes 0 to 3 route sense and bypass monitor; the disable code stops both
	task automatic s_mux();
		logic [2:0] c;
		logic b;
		for (int i = 0; i < 5; i++) begin
			c = (i < 4) ? 3'(i) : SEL_DISABLE;
			b = (i < 4) ? vbyp[i] : 1'b0;
			cmd({5'h1a, c});
			rd(8);
			chk({sel, byp, sen, rx[4], rx[7], 1'b0}, {c, b, i < 4, b, 2'b00});
			chk({7'h0, byp}, {7'h0, b});
		end
	endtask : s_mux

	// Off-state source on the selected channel only
	task automatic s_src();
		on_req = 4'hb;
		cmd(8'hc1);
		cmd(8'hda);
		chk({src, lvl, 3'h0}, 8'h48);
		on_req = 4'hf;
		tick(3);
		chk({src, 4'h0}, 8'h00);
		cmd(8'hdf);
		on_req = 4'h0;
		tick(3);
		chk({src, 4'h0}, 8'h00);
		cmd(8'hd7);
		on_req = 4'hf;
	endtask : s_src

	// Load type bits and configuration reset
	task automatic s_led();
		cmd(8'he8);
		chk({6'h0, led}, 8'h02);
		cmd(8'he2);
		chk({sel, led, 3'h0}, {SEL_RESET, LED_RESET, 3'h0});
	endtask : s_led

	// Over-load held until read, set again while it persists
	task automatic s_ovl();
		ol = 4'h4;
		tick(9);
		ol = 4'h0;
		tick(8);
		chk({4'h0, err}, 8'h04);
		rd(8);
		chk({rx[3:0], err}, 8'h40);
		chk({4'h0, rx[3:0]}, 8'h04);
		chk({4'h0, err}, 8'h00);
		ol = 4'h4;
		tick(10);
		rd(8);
		chk({rx[3:0], err}, 8'h44);
		on_req = 4'hb;
		rd(8);
		tick(10);
		chk({4'h0, err}, 8'h00);
		ol = 4'h0;
		on_req = 4'hf;
	endtask : s_ovl

	// Latches hold until clear-latch, first read after it still reports
	task automatic s_latch();
		cmd(8'hd0);
		ot = 4'h1;
		oc = 4'h2;
		tick(9);
		ot = 4'h0;
		oc = 4'h0;
		tick(8);
		chk({latch, 3'h0, sen}, 8'h30);
		rd(8);
		chk({rx[3:0], err}, 8'h33);
		cmd(8'he0);
		chk({latch, 4'h0}, 8'h30);
		cmd(8'he1);
		chk({latch, err}, 8'h03);
		rd(8);
		chk({rx[3:0], err}, 8'h30);
		chk({7'h0, sen}, 8'h01);
	endtask : s_latch

	// Restart retries latch at 8 for medium and 32 for low drain-source voltage
	task automatic s_retry();
		vmed = 4'h8;
		for (int i = 0; i < 8; i++) begin
			dts = 4'h8;
			tick(6);
			dts = 4'h0;
			tick(6);
			chk({7'h0, latch[3]}, {7'h0, i == 7});
		end
		chk({7'h0, err[3]}, 8'h01);
		cmd(8'he1);
		vmed = 4'h0;
		for (int i = 0; i < 32; i++) begin
			oc = 4'h4;
			tick(6);
			oc = 4'h0;
			tick(6);
			if (i >= 30) chk({7'h0, latch[2]}, {7'h0, i == 31});
		end
		cmd(8'he1);
		rd(8);
	endtask : s_retry

	// Short frame flagged in the next word, limp home reported
	task automatic s_short();
		limp = 1'b1;
		tick(6);
		chk({7'h0, miso_oe}, 8'h00);
		fork
			rd(3);
			begin
				#150;
				chk({7'h0, miso_oe}, 8'h01);
			end
		join
		rd(8);
		chk({5'h0, rx[7:5]}, 8'h05);
	endtask : s_short

	// Run-time limit
	initial begin
		#500us;
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{rst_n, limp} = 2'b00;
		{on_req, ot, oc, ol, dts, vmed} = 24'h0;
		vbyp = 4'h5;
		miscompares = 0;
		checked = 0;
		tick(5);
		chk({sel, led, byp, sen, lvl}, {SEL_RESET, LED_RESET, 3'h0});
		chk({latch, err}, 8'h00);
		chk({src, 4'h0}, 8'h00);
		rst_n = 1'b1;
		on_req = 4'hf;
		tick(6);
		s_mux();
		s_src();
		s_led();
		s_ovl();
		s_latch();
		s_retry();
		s_short();
		report_and_stop();
	end
endmodule : psd_diag_tb
